// [hdl/frt_defs.svh]
/*
 * Offsets, field positions, reset values and timing counts of the free-running timer control block.
 * Assumes an 8-bit CPU bus with a 16-bit byte address.
 */
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

// Register byte addresses
`define FRT_ADDR_COUNTER_HI   16'hFF92
`define FRT_ADDR_COUNTER_LO   16'hFF93
`define FRT_ADDR_COMPARE_HI   16'hFF94
`define FRT_ADDR_COMPARE_LO   16'hFF95
`define FRT_ADDR_CAPCLK_CTRL  16'hFF96
`define FRT_ADDR_CMPOUT_CTRL  16'hFF97
`define FRT_ADDR_CAPTURE_A_HI 16'hFF98
`define FRT_ADDR_CAPTURE_A_LO 16'hFF99
`define FRT_ADDR_CAPTURE_B_HI 16'hFF9A
`define FRT_ADDR_CAPTURE_B_LO 16'hFF9B
`define FRT_ADDR_CAPTURE_C_HI 16'hFF9C
`define FRT_ADDR_CAPTURE_C_LO 16'hFF9D
`define FRT_ADDR_CAPTURE_D_HI 16'hFF9E
`define FRT_ADDR_CAPTURE_D_LO 16'hFF9F

// Reset values
`define FRT_CAPCLK_RESET      8'h00
`define FRT_CMPOUT_RESET      8'hE0
`define FRT_CMPOUT_FIXED_MASK 8'hE0
`define FRT_CMPOUT_RW_MASK    8'h1F
`define FRT_ZERO8             8'h00
`define FRT_ZERO16            16'h0000
`define FRT_ONE16             16'h0001

// Prescaler divide ratios, as tap bit indices of a 5-bit divide-by-32 prescaler counter
`define FRT_DIV2_BIT          0
`define FRT_DIV8_BIT          2
`define FRT_DIV32_BIT         4
`define FRT_PRESCALE_ONE      5'h01

// Capture channel indices
`define FRT_CH_A              0
`define FRT_CH_B              1
`define FRT_CH_C              2
`define FRT_CH_D              3
`define FRT_NUM_CH            4

`endif

// [hdl/frt_pkg.sv]
/*
 * Types of the free-running timer control block.
 * Assumes frt_defs.svh holds the numbers.
 */
package frt_pkg;

    // Counter clock source
    typedef enum logic [1:0] {
        FRT_CLK_DIV2,
        FRT_CLK_DIV8,
        FRT_CLK_DIV32,
        FRT_CLK_EXT
    } frt_clk_sel_t;

    // Capture and clock control register layout
    typedef struct packed {
        logic         edge_sel_a;
        logic         edge_sel_b;
        logic         edge_sel_c;
        logic         edge_sel_d;
        logic         buffer_en_a;
        logic         buffer_en_b;
        frt_clk_sel_t clk_sel;
    } frt_capclk_t;

    // Compare output control register layout
    typedef struct packed {
        logic [2:0] fixed_ones;
        logic       compare_reg_select;
        logic       compare_out_en_a;
        logic       compare_out_en_b;
        logic       compare_level_a;
        logic       compare_level_b;
    } frt_cmpout_t;

    // CPU byte access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } frt_cpu_req_t;

    // Edge detector state
    typedef struct packed {
        logic prev;
        logic event_q;
    } frt_edge_state_t;

    // Prescaler state
    typedef struct packed {
        logic [4:0] count;
        logic       src_prev;
        logic       tick;
    } frt_presc_state_t;

    // Main block state
    typedef struct packed {
        frt_capclk_t  capclk;
        frt_cmpout_t  cmpout;
        logic [7:0]   hold_latch;
        logic [7:0]   rdata;
        logic [15:0]  free_counter;
        logic [15:0]  compare_reg_a;
        logic [15:0]  compare_reg_b;
        logic [15:0]  capture_reg_a;
        logic [15:0]  capture_reg_b;
        logic [15:0]  capture_reg_c;
        logic [15:0]  capture_reg_d;
        logic [3:0]   capture_flag;
        logic         compare_pin_a;
        logic         compare_pin_b;
    } frt_state_t;

endpackage

// [hdl/frt_edge_detect.sv]
/*
 * Selected-edge detector for one capture pin.
 * Assumes the pin is synchronous to i_clk.
 */
`timescale 1ns/1ps
module frt_edge_detect (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    // Pin and edge choice
    input  wire logic i_pin,
    input  wire logic i_rising,
    // Event
    output logic      o_event
);
    frt_pkg::frt_edge_state_t st;
    frt_pkg::frt_edge_state_t next_st;

    // Falling edge when i_rising is 0, rising edge when 1
    always_comb begin
        next_st         = st;
        next_st.prev    = i_pin;
        next_st.event_q = i_rising ? (i_pin & ~st.prev) : (~i_pin & st.prev); // RQ2
    end

    // State register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_event = st.event_q;
endmodule // frt_edge_detect

// [hdl/frt_prescaler.sv]
/*
 * Counter clock source: system clock divided by 2, 8 or 32, or external clock rising edge.
 * Assumes the external clock is synchronous to i_clk.
 */
`timescale 1ns/1ps
`include "frt_defs.svh"
module frt_prescaler (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_arst_n,
    // Source choice and external clock
    input  wire frt_pkg::frt_clk_sel_t i_clk_sel,
    input  wire logic                  i_ext_clk,
    // Count pulse
    output logic                       o_tick
);
    frt_pkg::frt_presc_state_t st;
    frt_pkg::frt_presc_state_t next_st;
    logic                      src;

    // Pick the source level; the counter counts on its falling edge (internal) or rising edge (external)
    always_comb begin
        case (i_clk_sel)
            frt_pkg::FRT_CLK_DIV2:  src = st.count[`FRT_DIV2_BIT];
            frt_pkg::FRT_CLK_DIV8:  src = st.count[`FRT_DIV8_BIT];
            frt_pkg::FRT_CLK_DIV32: src = st.count[`FRT_DIV32_BIT];
            frt_pkg::FRT_CLK_EXT:   src = ~i_ext_clk;
            default:                src = 1'b0;
        endcase
    end

    // Free-running prefix counter and edge pulse
    always_comb begin
        next_st          = st;
        next_st.count    = st.count + `FRT_PRESCALE_ONE;
        next_st.src_prev = src;
        next_st.tick     = st.src_prev & ~src; // RQ5
    end

    // State register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule // frt_prescaler

// [hdl/frt_ctrl.sv]
/*
 * Free-running timer control and CPU access: capture/clock control, compare output control,
 * shared byte-holding latch for 16-bit counter, compare and capture registers.
 * Assumes a synchronous 8-bit CPU bus with one-cycle read and write strobes, and synchronous pins.
 */
// How it works
// (RQ1) Capture/clock control resets to zero, fully writable
// (RQ2) Edge select bit picks falling or rising
// (RQ3) Buffer A makes capture C the A buffer
// (RQ4) Buffer B makes capture D the B buffer
// (RQ5) Clock select: /2, /8, /32, external rising
// (RQ6) Compare output control resets to E0
// (RQ7) Its top three bits read one, ignore writes
// (RQ8) Shared compare addresses follow compare_reg_select
// (RQ9) Output enables gate the compare pins
// (RQ10) Compare match drives pin to chosen level
// (RQ11) 16-bit registers reached through byte latch
// (RQ12) Upper write latches; lower write commits all
// (RQ13) Upper read latches lower; lower reads latch
// (RQ14) Compare registers read directly, bypassing latch
// (RQ15) CPU accesses upper byte before lower byte
// (RQ16) Buffered capture shifts old value to buffer
// (RQ17) Buffered C/D edges still set flag
// (RQ18) One latch shared by all registers
`timescale 1ns/1ps
`include "frt_defs.svh"
module frt_ctrl (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_arst_n,
    input  wire logic                  i_standby,
    // CPU bus
    input  wire frt_pkg::frt_cpu_req_t i_cpu,
    output logic [7:0]                 o_rdata,
    // Capture pins and external clock
    input  wire logic [3:0]            i_capture_pin,
    input  wire logic                  i_ext_clk,
    input  wire logic [3:0]            i_capture_flag_clr,
    // Compare pins
    output logic                       o_compare_pin_a,
    output logic                       o_compare_pin_a_oe,
    output logic                       o_compare_pin_b,
    output logic                       o_compare_pin_b_oe,
    // Status
    output logic [3:0]                 o_capture_flag,
    output logic                       o_compare_match_a,
    output logic                       o_compare_match_b
);
    frt_pkg::frt_state_t st;
    frt_pkg::frt_state_t next_st;
    logic [3:0]          cap_evt;
    logic                tick;
    logic [3:0]          edge_rising;
    logic                match_a;
    logic                match_b;

    assign edge_rising = {st.capclk.edge_sel_d, st.capclk.edge_sel_c,
                          st.capclk.edge_sel_b, st.capclk.edge_sel_a};

    // One selected-edge detector per capture pin
    genvar g;
    generate
        for (g = 0; g < `FRT_NUM_CH; g++) begin : g_edge
            frt_edge_detect u_edge (
                .i_clk    (i_clk),
                .i_arst_n (i_arst_n),
                .i_pin    (i_capture_pin[g]),
                .i_rising (edge_rising[g]),
                .o_event  (cap_evt[g])
            );
        end
    endgenerate

    // Counter clock source
    frt_prescaler u_presc (
        .i_clk     (i_clk),
        .i_arst_n  (i_arst_n),
        .i_clk_sel (st.capclk.clk_sel),
        .i_ext_clk (i_ext_clk),
        .o_tick    (tick)
    );

    // Compare match is taken in the last state before the counter moves on
    assign match_a = tick && (st.free_counter == st.compare_reg_a);
    assign match_b = tick && (st.free_counter == st.compare_reg_b);

    // Next-state logic: CPU access, counting, capture, compare output
    always_comb begin
        logic [15:0] word;
        logic [15:0] rd_word;
        logic        is_hi;
        logic        is_lo;
        logic        hit16;
        logic        direct;
        word    = {st.hold_latch, i_cpu.wdata};
        rd_word = `FRT_ZERO16;
        is_hi   = 1'b0;
        is_lo   = 1'b0;
        hit16   = 1'b1;
        direct  = 1'b0;
        next_st = st;
        next_st.rdata = `FRT_ZERO8;

        // Address decode of the 16-bit registers
        case (i_cpu.addr)
            `FRT_ADDR_COUNTER_HI:   begin rd_word = st.free_counter; is_hi = 1'b1; end
            `FRT_ADDR_COUNTER_LO:   begin rd_word = st.free_counter; is_lo = 1'b1; end
            `FRT_ADDR_COMPARE_HI,
            `FRT_ADDR_COMPARE_LO: begin
                rd_word = st.cmpout.compare_reg_select ? st.compare_reg_b : st.compare_reg_a; // RQ8
                is_hi   = (i_cpu.addr == `FRT_ADDR_COMPARE_HI);
                is_lo   = ~is_hi;
                direct  = 1'b1;
            end
            `FRT_ADDR_CAPTURE_A_HI: begin rd_word = st.capture_reg_a; is_hi = 1'b1; end
            `FRT_ADDR_CAPTURE_A_LO: begin rd_word = st.capture_reg_a; is_lo = 1'b1; end
            `FRT_ADDR_CAPTURE_B_HI: begin rd_word = st.capture_reg_b; is_hi = 1'b1; end
            `FRT_ADDR_CAPTURE_B_LO: begin rd_word = st.capture_reg_b; is_lo = 1'b1; end
            `FRT_ADDR_CAPTURE_C_HI: begin rd_word = st.capture_reg_c; is_hi = 1'b1; end
            `FRT_ADDR_CAPTURE_C_LO: begin rd_word = st.capture_reg_c; is_lo = 1'b1; end
            `FRT_ADDR_CAPTURE_D_HI: begin rd_word = st.capture_reg_d; is_hi = 1'b1; end
            `FRT_ADDR_CAPTURE_D_LO: begin rd_word = st.capture_reg_d; is_lo = 1'b1; end
            default:                hit16 = 1'b0;
        endcase

        // Counter increment; a lower-byte write below takes priority
        if (tick) begin
            next_st.free_counter = st.free_counter + `FRT_ONE16;
        end

        // Captures: buffered channel shifts old value into its buffer first
        if (cap_evt[`FRT_CH_A]) begin
            next_st.capture_reg_a = st.free_counter;
            if (st.capclk.buffer_en_a) begin
                next_st.capture_reg_c = st.capture_reg_a; // RQ16
            end
        end
        if (cap_evt[`FRT_CH_B]) begin
            next_st.capture_reg_b = st.free_counter;
            if (st.capclk.buffer_en_b) begin
                next_st.capture_reg_d = st.capture_reg_b; // RQ16
            end
        end
        if (cap_evt[`FRT_CH_C] && !st.capclk.buffer_en_a) begin
            next_st.capture_reg_c = st.free_counter; // RQ3
        end
        if (cap_evt[`FRT_CH_D] && !st.capclk.buffer_en_b) begin
            next_st.capture_reg_d = st.free_counter; // RQ4
        end

        // Capture flags: a new event wins over a clear in the same cycle
        next_st.capture_flag = (st.capture_flag & ~i_capture_flag_clr) | cap_evt; // RQ17

        // Compare pins take the chosen level on a match
        if (match_a) begin
            next_st.compare_pin_a = st.cmpout.compare_level_a; // RQ10
        end
        if (match_b) begin
            next_st.compare_pin_b = st.cmpout.compare_level_b; // RQ10
        end

        // CPU reads
        if (i_cpu.rd) begin
            if (hit16 && (direct || is_hi)) begin
                next_st.rdata = is_hi ? rd_word[15:8] : rd_word[7:0]; // RQ14
                if (is_hi && !direct) begin
                    next_st.hold_latch = rd_word[7:0]; // RQ13 RQ18
                end
            end else if (hit16 && is_lo) begin
                next_st.rdata = st.hold_latch; // RQ13
            end else if (i_cpu.addr == `FRT_ADDR_CAPCLK_CTRL) begin
                next_st.rdata = st.capclk; // RQ1
            end else if (i_cpu.addr == `FRT_ADDR_CMPOUT_CTRL) begin
                next_st.rdata = st.cmpout | `FRT_CMPOUT_FIXED_MASK; // RQ7
            end
        end

        // CPU writes
        if (i_cpu.wr) begin
            if (hit16 && is_hi) begin
                next_st.hold_latch = i_cpu.wdata; // RQ12 RQ11 RQ18
            end else if (hit16 && is_lo) begin
                case (i_cpu.addr)
                    `FRT_ADDR_COUNTER_LO: next_st.free_counter = word; // RQ12
                    `FRT_ADDR_COMPARE_LO: begin
                        if (st.cmpout.compare_reg_select) begin
                            next_st.compare_reg_b = word; // RQ8
                        end else begin
                            next_st.compare_reg_a = word; // RQ8
                        end
                    end
                    default: ;
                endcase
            end else if (i_cpu.addr == `FRT_ADDR_CAPCLK_CTRL) begin
                next_st.capclk = i_cpu.wdata; // RQ1
            end else if (i_cpu.addr == `FRT_ADDR_CMPOUT_CTRL) begin
                next_st.cmpout = (i_cpu.wdata & `FRT_CMPOUT_RW_MASK) | `FRT_CMPOUT_FIXED_MASK; // RQ7
            end
        end

        // Standby returns both control registers to their reset values
        if (i_standby) begin
            next_st.capclk = `FRT_CAPCLK_RESET; // RQ1
            next_st.cmpout = `FRT_CMPOUT_RESET; // RQ6
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st        <= '0;
            st.cmpout <= `FRT_CMPOUT_RESET; // RQ6
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign o_rdata            = st.rdata;
    assign o_compare_pin_a    = st.compare_pin_a;
    assign o_compare_pin_b    = st.compare_pin_b;
    assign o_compare_pin_a_oe = st.cmpout.compare_out_en_a; // RQ9
    assign o_compare_pin_b_oe = st.cmpout.compare_out_en_b; // RQ9
    assign o_capture_flag     = st.capture_flag;
    assign o_compare_match_a  = match_a;
    assign o_compare_match_b  = match_b;
endmodule // frt_ctrl

// [verification/frt_cpu_model.sv]
/*
 * CPU side of the timer byte bus: one byte write or read per call.
 * Assumes the bench calls its tasks; requests change on the falling edge.
 */
`timescale 1ns/1ps
module frt_cpu_model (
    // Clock and bus
    input  wire logic             i_clk,
    input  wire logic [7:0]       i_rdata,
    output frt_pkg::frt_cpu_req_t o_cpu
);
    // Idle bus at time zero
    initial begin
        o_cpu = '0;
    end

    // Byte write over one rising edge; released lines show inverted values
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_cpu = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge i_clk);
        o_cpu = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Byte read; data is taken the cycle after the strobe
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_cpu = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'hFF};
        @(negedge i_clk);
        d = i_rdata;
        o_cpu = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'h00};
    endtask
endmodule // frt_cpu_model

// [verification/frt_ctrl_checker.sv]
/*
 * Port checker of the timer control block.
 * Assumes the one clock domain of frt_ctrl; bound at the foot.
 */
`timescale 1ns/1ps
`include "frt_defs.svh"
module frt_ctrl_checker (
    // Clock, reset, bus
    input wire logic                  i_clk,
    input wire logic                  i_arst_n,
    input wire logic                  i_standby,
    input wire frt_pkg::frt_cpu_req_t i_cpu,
    input wire logic [7:0]            o_rdata,
    // Pins and flags
    input wire logic [3:0]            i_capture_pin,
    input wire logic                  o_compare_pin_a,
    input wire logic                  o_compare_pin_a_oe,
    input wire logic                  o_compare_pin_b,
    input wire logic                  o_compare_pin_b_oe,
    input wire logic [3:0]            o_capture_flag,
    input wire logic                  o_compare_match_a,
    input wire logic                  o_compare_match_b
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    logic [7:0] cc_q;
    logic [4:0] co_q;
    logic       wr97;

    // Compare output control writes seen on the bus
    assign wr97 = i_cpu.wr && (i_cpu.addr == `FRT_ADDR_CMPOUT_CTRL);

    // Shadow of both control registers
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cc_q <= 8'h00;
            co_q <= 5'h00;
        end else if (i_standby) begin
            cc_q <= 8'h00;
            co_q <= 5'h00;
        end else begin
            if (i_cpu.wr && i_cpu.addr == `FRT_ADDR_CAPCLK_CTRL) cc_q <= i_cpu.wdata;
            if (wr97) co_q <= i_cpu.wdata[4:0];
        end
    end

    sequence s_edge_a;
        cc_q[7] ? $rose(i_capture_pin[0]) : $fell(i_capture_pin[0]);
    endsequence
    sequence s_edge_c;
        cc_q[5] && cc_q[3] && $rose(i_capture_pin[2]);
    endsequence

    capclk_read_a: assert property (i_cpu.rd && i_cpu.addr == `FRT_ADDR_CAPCLK_CTRL |=>
        o_rdata == $past(cc_q)) else $error("capclk readback wrong");
    cmpout_read_a: assert property (i_cpu.rd && i_cpu.addr == `FRT_ADDR_CMPOUT_CTRL |=>
        o_rdata == {3'b111, $past(co_q)}) else $error("cmpout readback wrong");
    rdata_idle_a: assert property (!i_cpu.rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    oe_a_follow_a: assert property (!$past(wr97 || i_standby) |-> o_compare_pin_a_oe == co_q[3])
        else $error("enable a wrong");
    oe_b_follow_a: assert property (!$past(wr97 || i_standby) |-> o_compare_pin_b_oe == co_q[2])
        else $error("enable b wrong");
    pin_a_level_a: assert property (o_compare_match_a |=> o_compare_pin_a == $past(co_q[1]))
        else $error("pin a level wrong");
    pin_b_level_a: assert property (o_compare_match_b |=> o_compare_pin_b == $past(co_q[0]))
        else $error("pin b level wrong");
    flag_a_edge_a: assert property (s_edge_a |-> ##[1:3] o_capture_flag[0])
        else $error("flag a missing");
    flag_c_buffered_a: assert property (s_edge_c |-> ##[1:3] o_capture_flag[2])
        else $error("flag c missing");
endmodule // frt_ctrl_checker

bind frt_ctrl frt_ctrl_checker u_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_standby(i_standby), .i_cpu(i_cpu),
    .o_rdata(o_rdata), .i_capture_pin(i_capture_pin), .o_compare_pin_a(o_compare_pin_a),
    .o_compare_pin_a_oe(o_compare_pin_a_oe), .o_compare_pin_b(o_compare_pin_b),
    .o_compare_pin_b_oe(o_compare_pin_b_oe), .o_capture_flag(o_capture_flag),
    .o_compare_match_a(o_compare_match_a), .o_compare_match_b(o_compare_match_b));

// [verification/tb_free_running_timer_ctrl_access.sv]
/*
 * Self-checking bench of the timer control block against an integer model.
 * Assumes frt_cpu_model makes bus cycles; inputs change on the falling edge.
 */
`timescale 1ns/1ps
`include "frt_defs.svh"
module tb_free_running_timer_ctrl_access;
    logic                  i_clk, i_arst_n, i_standby, i_ext_clk;
    logic [3:0]            i_capture_pin, i_capture_flag_clr, o_capture_flag;
    frt_pkg::frt_cpu_req_t i_cpu;
    logic [7:0]            o_rdata, b, b2;
    logic                  o_compare_pin_a, o_compare_pin_a_oe, o_compare_pin_b, o_compare_pin_b_oe;
    logic [15:0]           w;
    int                    errors, samples_checked, cycles, seed;
    int                    cc, co, latch, cnt, pa, pb, flags;
    int                    cmp[2], cap[4];

    frt_ctrl u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_standby(i_standby), .i_cpu(i_cpu),
        .o_rdata(o_rdata), .i_capture_pin(i_capture_pin), .i_ext_clk(i_ext_clk),
        .i_capture_flag_clr(i_capture_flag_clr), .o_compare_pin_a(o_compare_pin_a),
        .o_compare_pin_a_oe(o_compare_pin_a_oe), .o_compare_pin_b(o_compare_pin_b),
        .o_compare_pin_b_oe(o_compare_pin_b_oe), .o_capture_flag(o_capture_flag),
        .o_compare_match_a(), .o_compare_match_b());
    frt_cpu_model u_cpu (.i_clk(i_clk), .i_rdata(o_rdata), .o_cpu(i_cpu));

    // Clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic give_verdict();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Counter value within two counts of the expected one
    task automatic chk_near(input logic [15:0] got, input int exp);
        samples_checked++;
        if ($isunknown(got) || int'(got) > exp + 2 || int'(got) + 2 < exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus write plus model update
    task automatic bwr(input logic [15:0] a, input int d);
        u_cpu.wr8(a, d[7:0]);
        case (a)
            `FRT_ADDR_CAPCLK_CTRL: cc = d & 255;
            `FRT_ADDR_CMPOUT_CTRL: co = (d & 31) | 224;
            `FRT_ADDR_COUNTER_LO: cnt = latch * 256 + (d & 255);
            `FRT_ADDR_COMPARE_LO: cmp[(co >> 4) & 1] = latch * 256 + (d & 255);
            default: begin
                if (a[0] == 1'b0 && a >= `FRT_ADDR_COUNTER_HI && a <= `FRT_ADDR_CAPTURE_D_HI) latch = d & 255;
            end
        endcase
    endtask

    // Bus read compared with the model
    task automatic brd(input logic [15:0] a);
        int e;
        int k;
        u_cpu.rd8(a, b);
        k = (int'(a) - int'(`FRT_ADDR_CAPTURE_A_HI)) >> 1;
        e = 0;
        case (a)
            `FRT_ADDR_CAPCLK_CTRL: e = cc;
            `FRT_ADDR_CMPOUT_CTRL: e = co;
            `FRT_ADDR_COUNTER_HI: begin
                e = cnt >> 8;
                latch = cnt & 255;
            end
            `FRT_ADDR_COMPARE_HI: e = cmp[(co >> 4) & 1] >> 8;
            `FRT_ADDR_COMPARE_LO: e = cmp[(co >> 4) & 1] & 255;
            `FRT_ADDR_COUNTER_LO: e = latch;
            default: begin
                if (a >= `FRT_ADDR_CAPTURE_A_HI && a <= `FRT_ADDR_CAPTURE_D_LO) begin
                    e = a[0] ? latch : (cap[k] >> 8);
                    if (!a[0]) latch = cap[k] & 255;
                end
            end
        endcase
        chk({8'h00, b}, e[15:0]);
    endtask

    // Word accesses, upper byte first
    task automatic bwr16(input logic [15:0] a, input int d);
        bwr(a, d >> 8);
        bwr(a + 16'h0001, d);
    endtask
    task automatic brd16(input logic [15:0] a);
        brd(a);
        brd(a + 16'h0001);
    endtask

    // External count pulse; a match takes the counter value before the step
    task automatic tick();
        if (cnt == cmp[0]) pa = (co >> 1) & 1;
        if (cnt == cmp[1]) pb = co & 1;
        cnt = (cnt + 1) & 65535;
        @(negedge i_clk);
        i_ext_clk = 1'b1;
        repeat (3) @(negedge i_clk);
        i_ext_clk = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask

    // Capture pin change with model of edge choice and buffering
    task automatic pin(input int ch, input logic v);
        if (v !== i_capture_pin[ch] && int'(v) == ((cc >> (7 - ch)) & 1)) begin
            flags |= 1 << ch;
            if (ch == 0 && (cc & 8) != 0) cap[2] = cap[0];
            if (ch == 1 && (cc & 4) != 0) cap[3] = cap[1];
            if (!(ch == 2 && (cc & 8) != 0) && !(ch == 3 && (cc & 4) != 0)) cap[ch] = cnt;
        end
        @(negedge i_clk);
        i_capture_pin[ch] = v;
        repeat (4) @(negedge i_clk);
        chk({12'h000, o_capture_flag}, flags[15:0]);
    endtask

    initial begin
        seed = 32'hd36c_4356;
        {errors, samples_checked, cycles, latch, cnt, pa, pb, flags, cc} = '0;
        co = 224;
        cmp = '{0, 0};
        cap = '{0, 0, 0, 0};
        {i_arst_n, i_standby, i_ext_clk, i_capture_pin, i_capture_flag_clr} = '0;
        repeat (10) @(negedge i_clk);
        i_arst_n = 1'b1;
        brd(`FRT_ADDR_CAPCLK_CTRL);
        brd(`FRT_ADDR_CMPOUT_CTRL);
        // Random control values and an unmapped place
        repeat (4) begin
            bwr(`FRT_ADDR_CAPCLK_CTRL, $random(seed));
            bwr(`FRT_ADDR_CMPOUT_CTRL, $random(seed));
            bwr(16'hFFA0, $random(seed));
            brd(`FRT_ADDR_CAPCLK_CTRL);
            brd(`FRT_ADDR_CMPOUT_CTRL);
            brd(16'hFFA0);
        end
        // Standby returns both registers to reset values
        @(negedge i_clk);
        i_standby = 1'b1;
        repeat (2) @(negedge i_clk);
        i_standby = 1'b0;
        cc = 0;
        co = 224;
        brd(`FRT_ADDR_CAPCLK_CTRL);
        brd(`FRT_ADDR_CMPOUT_CTRL);
        // Internal divide ratios
        for (int s = 0; s < 3; s++) begin
            bwr(`FRT_ADDR_CAPCLK_CTRL, s);
            bwr16(`FRT_ADDR_COUNTER_HI, 0);
            repeat (256) @(negedge i_clk);
            u_cpu.rd8(`FRT_ADDR_COUNTER_HI, b);
            u_cpu.rd8(`FRT_ADDR_COUNTER_LO, b2);
            chk_near({b, b2}, 258 / (2 << (2 * s)));
        end
        // External clock, rising edges of A buffered, C as plain flag
        w = 16'($random(seed));
        bwr(`FRT_ADDR_CAPCLK_CTRL, 8'hAB);
        bwr16(`FRT_ADDR_COUNTER_HI, w);
        brd16(`FRT_ADDR_COUNTER_HI);
        bwr(`FRT_ADDR_CMPOUT_CTRL, 8'h00);
        bwr16(`FRT_ADDR_COMPARE_HI, w + 1);
        bwr(`FRT_ADDR_CMPOUT_CTRL, 8'h10);
        bwr16(`FRT_ADDR_COMPARE_HI, w + 1);
        brd(`FRT_ADDR_COMPARE_LO);
        brd(`FRT_ADDR_COMPARE_HI);
        bwr(`FRT_ADDR_CMPOUT_CTRL, 8'h0F);
        brd16(`FRT_ADDR_COMPARE_HI);
        chk({14'h0000, o_compare_pin_b_oe, o_compare_pin_a_oe}, 16'h0003);
        tick();
        chk({14'h0000, o_compare_pin_b, o_compare_pin_a}, 16'(pb * 2 + pa));
        tick();
        chk({14'h0000, o_compare_pin_b, o_compare_pin_a}, 16'(pb * 2 + pa));
        pin(0, 1'b1);
        tick();
        pin(0, 1'b0);
        pin(0, 1'b1);
        pin(2, 1'b1);
        pin(1, 1'b1);
        pin(1, 1'b0);
        pin(3, 1'b1);
        pin(3, 1'b0);
        for (int k = 0; k < 4; k++) brd16(`FRT_ADDR_CAPTURE_A_HI + 16'(2 * k));
        // Shared latch between registers
        bwr(`FRT_ADDR_COUNTER_HI, 8'h5A);
        brd(`FRT_ADDR_CAPTURE_A_HI);
        bwr(`FRT_ADDR_COUNTER_LO, 8'h3C);
        brd16(`FRT_ADDR_COUNTER_HI);
        // Flag clear, then C captures again without buffering
        @(negedge i_clk);
        i_capture_flag_clr = 4'hF;
        @(negedge i_clk);
        i_capture_flag_clr = 4'h0;
        flags = 0;
        bwr(`FRT_ADDR_CAPCLK_CTRL, 8'hA3);
        pin(2, 1'b0);
        pin(2, 1'b1);
        brd16(`FRT_ADDR_CAPTURE_C_HI);
        give_verdict();
    end
endmodule // tb_free_running_timer_ctrl_access
